// *** logic/gated_cascadable_timers.sv ***
// four gated, cascadable timers behind an AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
// Contract
// - four timers, each with own output pin
// - output event when count reaches reference
// - per timer choose low pulse or toggle
// - timer output can clock next timer
// - external gate holds or restarts counting
// - gate one serves timers 1-2, two 3-4
// - clock source: cascade, sysclk, sysclk/16, pin
// - four timer input pins, selectable counting edge
module gated_cascadable_timers (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [timers_pkg::NUM_TIMERS-1:0] timer_in_pins,
  input wire logic gate_in_pair_low_n,
  input wire logic gate_in_pair_high_n,
  output logic [timers_pkg::NUM_TIMERS-1:0] timer_out_pins,
  output logic irq
);

  localparam int N = timers_pkg::NUM_TIMERS;

  // register map (byte offsets, one word each, unused bits read zero):
  //   channel n at n*16: +0 ctrl, +4 reference, +8 count (read only)
  //   ctrl bits: [0] enable, [1] toggle not pulse, [3:2] clock source,
  //   [5:4] gate use (hold, restart), [7:6] pin edge for source pin
  //   0x40 status, write one to clear; 0x44 mask; 0x48 pin levels
  // the slave never waits: hreadyout is high from the first edge after
  // reset, and a write lands at the edge that closes its data phase

  timers_pkg::top_s s_reg;
  timers_pkg::top_s s_next;
  timers_pkg::chan_in_s [N-1:0] stim;
  timers_pkg::chan_state_s [N-1:0] chan;

  // true when addr selects register ofs within a channel block, false for the shared words
  function automatic logic chan_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    chan_hit = (addr < timers_pkg::OFS_STATUS) && (addr[3:0] == ofs[3:0]);
  endfunction : chan_hit

  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input timers_pkg::top_s st,
    input timers_pkg::chan_state_s [N-1:0] ch
  );
    logic [1:0] idx;
    idx = addr[5:4];
    read_word = '0;
    if (chan_hit(addr, timers_pkg::OFS_CTRL)) begin
      read_word[timers_pkg::CTRL_W-1:0] = st.cfg[idx];
    end else if (chan_hit(addr, timers_pkg::OFS_REF)) begin
      read_word[timers_pkg::CNT_W-1:0] = st.refv[idx];
    end else if (chan_hit(addr, timers_pkg::OFS_CNT)) begin
      read_word[timers_pkg::CNT_W-1:0] = ch[idx].cnt;
    end else if (addr == timers_pkg::OFS_STATUS) begin
      read_word[N-1:0] = st.status;
    end else if (addr == timers_pkg::OFS_MASK) begin
      read_word[N-1:0] = st.mask;
    end else if (addr == timers_pkg::OFS_PINS) begin
      read_word[timers_pkg::PINS_TIN_LSB +: N] = st.tin_s2;
      read_word[timers_pkg::PINS_GATE_LSB +: 2] = st.gate_s2;
      for (int i = 0; i < N; i++) begin
        read_word[timers_pkg::PINS_OUT_LSB + i] = ch[i].out;
      end
    end
  endfunction : read_word

  // data-phase write of one word; count and pins words ignore writes
  function automatic timers_pkg::top_s write_word(
    input timers_pkg::top_s st,
    input logic [7:0] addr,
    input logic [31:0] data
  );
    logic [1:0] idx;
    idx = addr[5:4];
    write_word = st;
    if (chan_hit(addr, timers_pkg::OFS_CTRL)) begin
      write_word.cfg[idx] = timers_pkg::chan_cfg_s'(
        data[timers_pkg::CTRL_W-1:0]);
    end else if (chan_hit(addr, timers_pkg::OFS_REF)) begin
      write_word.refv[idx] = data[timers_pkg::CNT_W-1:0];
    end else if (addr == timers_pkg::OFS_STATUS) begin
      write_word.status = st.status & ~data[N-1:0];
    end else if (addr == timers_pkg::OFS_MASK) begin
      write_word.mask = data[N-1:0];
    end
  endfunction : write_word

  // per-channel tick: cascade hit, every clock, prescaler strobe or pin edge
  function automatic logic pick_tick(
    input timers_pkg::chan_cfg_s c,
    input logic casc,
    input logic sys16,
    input logic rise,
    input logic fall
  );
    pick_tick = 1'b0;
    case (c.src)
      timers_pkg::SRC_CASCADE: pick_tick = casc;
      timers_pkg::SRC_SYS: pick_tick = 1'b1;
      timers_pkg::SRC_SYS16: pick_tick = sys16;
      timers_pkg::SRC_PIN: begin
        // a pin edge counts once, on the cycle after it reaches stage two
        case (c.edge_sel)
          timers_pkg::EDGE_RISE: pick_tick = rise;
          timers_pkg::EDGE_FALL: pick_tick = fall;
          timers_pkg::EDGE_BOTH: pick_tick = rise | fall;
          // no edge selected leaves a pin-clocked timer frozen
          default: pick_tick = 1'b0;
        endcase
      end
      default: pick_tick = 1'b0;
    endcase
  endfunction : pick_tick

  always_comb begin
    logic take;
    logic sys16;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [1:0] gate_fall;
    logic [1:0] g;
    logic [N-1:0] hits;
    take = 1'b0;
    sys16 = 1'b0;
    rise = '0;
    fall = '0;
    gate_fall = '0;
    g = '0;
    hits = '0;
    stim = '0;
    s_next = s_reg;

    // two-stage synchronisers; stage three only remembers the last level
    s_next.tin_s1 = timer_in_pins;
    s_next.tin_s2 = s_reg.tin_s1;
    s_next.tin_s3 = s_reg.tin_s2;
    s_next.gate_s1 = {gate_in_pair_high_n, gate_in_pair_low_n};
    s_next.gate_s2 = s_reg.gate_s1;
    s_next.gate_s3 = s_reg.gate_s2;
    rise = s_reg.tin_s2 & ~s_reg.tin_s3;
    fall = ~s_reg.tin_s2 & s_reg.tin_s3;
    gate_fall = ~s_reg.gate_s2 & s_reg.gate_s3;

    // shared divide-by-sixteen strobe
    s_next.pre = s_reg.pre + 4'h1;
    sys16 = (s_reg.pre == timers_pkg::PRE_LAST);

    for (int i = 0; i < N; i++) begin
      hits[i] = chan[i].hit;
      g = s_reg.gate_s2 >> (i / 2);
      // cascade reads the registered hit, one clock behind the source timer
      stim[i].tick = pick_tick(s_reg.cfg[i], chan[(i + N - 1) % N].hit,
                               sys16, rise[i], fall[i]);
      // gate low lets counting run; its falling edge restarts
      stim[i].gate_open = !(s_reg.cfg[i].gate[0] && g[0]);
      stim[i].restart = s_reg.cfg[i].gate[1] && gate_fall[i / 2];
    end

    // AHB-Lite data phase: writes land one cycle after their address
    if (s_reg.dp_wr) begin
      s_next = write_word(s_next, s_reg.dp_addr, hwdata);
    end
    // a reference event in the clearing cycle survives the clear
    s_next.status = s_next.status | hits;
    s_next.irq = |(s_next.status & s_next.mask);

    // only NONSEQ or SEQ with hready high opens a transfer
    take = hsel && htrans[1] && hready;
    s_next.dp_wr = take && hwrite;
    s_next.rdy = 1'b1;
    s_next.resp = 1'b0;
    if (take) begin
      s_next.dp_addr = haddr[timers_pkg::ADDR_W-1:0];
    end
    // read data uses post-write state so a write then read sees new data
    if (take && !hwrite) begin
      s_next.rdata = read_word(haddr[timers_pkg::ADDR_W-1:0], s_next, chan);
    end else begin
      s_next.rdata = '0;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_chan
    timer_channel u_chan (
      .clk(clk),
      .nrst(nrst),
      .cfg(s_reg.cfg[i]),
      .ref_val(s_reg.refv[i]),
      .stim(stim[i]),
      .state(chan[i])
    );
    assign timer_out_pins[i] = chan[i].out;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= timers_pkg::TOP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.rdy;
  assign hrdata = s_reg.rdata;
  assign hresp = s_reg.resp;
  assign irq = s_reg.irq;

endmodule : gated_cascadable_timers
`default_nettype wire

// *** logic/timer_channel.sv ***
// one 16-bit timer channel: counter, reference compare and pin shaping
`timescale 1ns/100ps
`default_nettype none
module timer_channel (
  input wire logic clk,
  input wire logic nrst,
  input wire timers_pkg::chan_cfg_s cfg,
  input wire logic [timers_pkg::CNT_W-1:0] ref_val,
  input wire timers_pkg::chan_in_s stim,
  output timers_pkg::chan_state_s state
);

  timers_pkg::chan_state_s s_reg;
  timers_pkg::chan_state_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.hit = 1'b0;
    if (!cfg.en) begin
      s_next.cnt = '0;
      s_next.pulse_low = 1'b0;
      s_next.out = 1'b1;
    end else if (stim.restart) begin
      s_next.cnt = '0;
    end else if (stim.tick && stim.gate_open) begin
      // a pulse ends on the next counted tick of this timer
      if (s_reg.pulse_low) begin
        s_next.pulse_low = 1'b0;
        s_next.out = 1'b1;
      end
      if (s_reg.cnt == ref_val) begin
        s_next.cnt = '0;
        s_next.hit = 1'b1;
        if (cfg.mode == timers_pkg::OUT_PULSE) begin
          s_next.out = 1'b0;
          s_next.pulse_low = 1'b1;
        end else begin
          s_next.out = ~s_reg.out;
        end
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= timers_pkg::CHAN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign state = s_reg;

endmodule : timer_channel
`default_nettype wire

// *** logic/timers_pkg.sv ***
// shared constants, types and register map of the four-timer bank
package timers_pkg;

  localparam int NUM_TIMERS = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // register byte offsets; each channel owns a block of CHAN_STRIDE bytes
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REF = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] CHAN_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_MASK = 8'h44;
  localparam logic [7:0] OFS_PINS = 8'h48;

  // control word field positions (match chan_cfg_s packing)
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_GATE_LSB = 4;
  localparam int CTRL_EDGE_LSB = 6;
  localparam int CTRL_W = 8;

  // pins register field positions
  localparam int PINS_TIN_LSB = 0;
  localparam int PINS_GATE_LSB = 4;
  localparam int PINS_OUT_LSB = 8;

  localparam logic [CNT_W-1:0] REF_RESET = 16'hffff;
  localparam int SYS16_DIV = 16;
  localparam logic [3:0] PRE_LAST = 4'(SYS16_DIV - 1);

  typedef enum logic [1:0] {
    SRC_CASCADE, SRC_SYS, SRC_SYS16, SRC_PIN
  } clk_src_e;
  typedef enum logic [1:0] {
    GATE_OFF, GATE_HOLD, GATE_RESTART, GATE_HOLD_RESTART
  } gate_mode_e;
  typedef enum logic [1:0] {
    EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE
  } edge_e;
  typedef enum logic {OUT_PULSE, OUT_TOGGLE} out_mode_e;

  typedef struct packed {
    edge_e edge_sel;
    gate_mode_e gate;
    clk_src_e src;
    out_mode_e mode;
    logic en;
  } chan_cfg_s;

  typedef struct packed {
    logic tick;
    logic gate_open;
    logic restart;
  } chan_in_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
    logic hit;
    logic pulse_low;
  } chan_state_s;

  localparam chan_state_s CHAN_RESET = '{cnt: '0, out: 1'b1, hit: 1'b0,
                                         pulse_low: 1'b0};

  typedef struct packed {
    logic [NUM_TIMERS-1:0] tin_s1;
    logic [NUM_TIMERS-1:0] tin_s2;
    logic [NUM_TIMERS-1:0] tin_s3;
    logic [1:0] gate_s1;
    logic [1:0] gate_s2;
    logic [1:0] gate_s3;
    logic [3:0] pre;
    logic dp_wr;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    chan_cfg_s [NUM_TIMERS-1:0] cfg;
    logic [NUM_TIMERS-1:0][CNT_W-1:0] refv;
    logic [NUM_TIMERS-1:0] status;
    logic [NUM_TIMERS-1:0] mask;
    logic irq;
  } top_s;

  // gate pins are active low, so their synchronisers idle high
  localparam top_s TOP_RESET = '{
    gate_s1: 2'h3, gate_s2: 2'h3, gate_s3: 2'h3,
    refv: {NUM_TIMERS{REF_RESET}},
    default: '0
  };

endpackage : timers_pkg

// *** testbench/ext_pins_model.sv ***
// far side: timer input sources and the two gate drivers
`timescale 1ns/100ps
`default_nettype none
module ext_pins_model (
  input wire logic clk,
  output logic [3:0] tin,
  output logic gate_lo_n,
  output logic gate_hi_n
);
  initial begin
    tin = 4'h0;
    // gates start released, matching the synchronisers' reset level
    gate_lo_n = 1'b1;
    gate_hi_n = 1'b1;
  end
  // levels held four clocks so the synchronisers never miss one
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      tin[i] <= 1'b1;
      repeat (4) @(posedge clk);
      tin[i] <= 1'b0;
    end
  endtask : pulse
  task automatic gates(input logic lo, input logic hi);
    @(posedge clk);
    gate_lo_n <= lo;
    gate_hi_n <= hi;
  endtask : gates
endmodule : ext_pins_model
`default_nettype wire

// *** testbench/gated_cascadable_timers_tb.sv ***
// self-checking bench for the timer bank over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module gated_cascadable_timers_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, glo_n, ghi_n;
  logic [31:0] hrdata, rd, a;
  logic [3:0] tin, pins;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] edge_exp [4] = '{2, 2, 4, 0};
  always #25 clk = ~clk;
  gated_cascadable_timers dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .timer_in_pins(tin), .gate_in_pair_low_n(glo_n),
    .gate_in_pair_high_n(ghi_n), .timer_out_pins(pins), .irq);
  ext_pins_model ext (.clk, .tin, .gate_lo_n(glo_n), .gate_hi_n(ghi_n));
  // ready is sampled at the rising edge; read data taken at the last one
  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // cycles until pin i next changes; back-to-back calls measure each level
  task automatic span(input int i, output int n);
    logic v;
    if (clk === 1'b1) @(negedge clk);
    v = pins[i];
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pins[i] === v && n < 100);
  endtask : span
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    int n;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 8'h04, 0); check(rd, 32'hffff);
    bus(0, 8'h4c, 0); check(rd, 0);
    bus(1, 8'h04, 4);
    bus(1, 8'h00, 32'h05);
    span(0, n);
    span(0, n); check(n, 1);
    span(0, n); check(n, 4);
    bus(1, 8'h00, 0);
    bus(1, 8'h44, 2);
    bus(0, 8'h44, 0); check(rd, 2);
    bus(1, 8'h14, 2);
    bus(1, 8'h10, 32'h07);
    span(1, n);
    span(1, n); check(n, 3);
    check({31'h0, irq}, 1);
    bus(1, 8'h10, 0);
    bus(1, 8'h40, 3);
    bus(0, 8'h40, 0); check(rd, 0);
    check({31'h0, irq}, 0);
    bus(1, 8'h34, 1);
    bus(1, 8'h30, 32'h03);
    bus(1, 8'h24, 1);
    bus(1, 8'h20, 32'h07);
    span(3, n);
    span(3, n); check(n, 4);
    bus(1, 8'h14, 0);
    bus(1, 8'h10, 32'h0b);
    span(1, n);
    span(1, n); check(n, 16);
    bus(1, 8'h04, 32'hffff);
    ext.gates(1, 0);
    bus(1, 8'h00, 32'h17);
    repeat (8) @(negedge clk);
    bus(0, 8'h08, 0); check(rd, 0);
    ext.gates(0, 1);
    repeat (8) @(negedge clk);
    bus(0, 8'h08, 0); check({31'h0, rd == 0}, 0);
    bus(1, 8'h00, 32'h27);
    ext.gates(1, 1);
    repeat (20) @(negedge clk);
    bus(0, 8'h08, 0);
    a = rd;
    ext.gates(0, 1);
    repeat (6) @(negedge clk);
    bus(0, 8'h08, 0); check({31'h0, rd >= a}, 0);
    bus(1, 8'h14, 32'hffff);
    for (int e = 0; e < 4; e++) begin
      bus(1, 8'h10, 0);
      bus(1, 8'h10, 32'h0f | (e << 6));
      ext.pulse(1, 2);
      repeat (6) @(negedge clk);
      bus(0, 8'h18, 0); check(rd, edge_exp[e]);
    end
    final_report();
  end
endmodule : gated_cascadable_timers_tb
`default_nettype wire

// *** testbench/gct_props.sv ***
// concurrent checks on the timer bank ports
`timescale 1ns/100ps
`default_nettype none
module gct_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [3:0] timer_out_pins,
  input wire logic irq
);
  logic rd_q, wr_q, nz0;
  logic [7:0] a_q, ctl0;
  logic [3:0] mask_sh, en_sh;
  wire logic take = hsel && htrans[1] && hready;
  // shadows follow writes at the edge that closes the data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
      ctl0 <= 8'h00;
      nz0 <= 1'b1;
      mask_sh <= 4'h0;
      en_sh <= 4'h0;
    end else begin
      rd_q <= take && !hwrite;
      wr_q <= take && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == timers_pkg::OFS_MASK) mask_sh <= hwdata[3:0];
      if (wr_q && a_q[7:6] == 2'h0 && a_q[3:0] == 4'h0) begin
        en_sh[a_q[5:4]] <= hwdata[0];
      end
      if (wr_q && a_q == 8'h00) ctl0 <= hwdata[7:0];
      if (wr_q && a_q == 8'h04) nz0 <= hwdata[15:0] != 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_mask_s;
    rd_q && a_q == timers_pkg::OFS_MASK;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_ready_stays: assert property ($past(hreadyout) |-> hreadyout)
    else $error("wait state inserted");
  a_rdata_quiet: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_mask_readback: assert property (rd_mask_s |-> hrdata == {28'h0, mask_sh})
    else $error("mask readback");
  a_unmapped_zero: assert property (rd_q && a_q == 8'h4c |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (irq |-> (mask_sh | $past(mask_sh)) != 4'h0)
    else $error("irq with all masked");
  // two cycles of slack for the cfg and pin registers
  a_disabled_high: assert property ((~(en_sh | $past(en_sh) |
    $past(en_sh, 2)) & ~timer_out_pins) == 4'h0)
    else $error("disabled timer pin low");
  a_pulse_one: assert property ($fell(timer_out_pins[0]) &&
    ctl0 == 8'h05 && nz0 |=> timer_out_pins[0])
    else $error("pulse longer than one tick");
endmodule : gct_props
bind gated_cascadable_timers gct_props chk (.clk, .nrst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
  .timer_out_pins, .irq);
`default_nettype wire
